// *** lbbg_defines.vh ***
// register map, field positions, reset values and timing counts
`ifndef LBBG_DEFINES_VH
`define LBBG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LBBG_REG_MODE 4'h0
`define LBBG_REG_CTRL 4'h1
`define LBBG_REG_ERR 4'h2
`define LBBG_REG_TXBUF 4'h3
`define LBBG_REG_RXBUF 4'h4
`define LBBG_REG_CKSEL 4'h5
`define LBBG_REG_BAUD 4'h6
`define LBBG_REG_TXSTAT 4'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LBBG_MODE_POWER 7
`define LBBG_MODE_TXE 6
`define LBBG_MODE_RXE 5
`define LBBG_CTRL_BRF 7
`define LBBG_CTRL_BRT 6
`define LBBG_CTRL_BTT 5
`define LBBG_CTRL_BLEN_HI 4
`define LBBG_CTRL_BLEN_LO 2
`define LBBG_ERR_OVE 0
`define LBBG_ERR_FE 1
`define LBBG_ERR_PE 2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define LBBG_RXBUF_RST 8'hff
`define LBBG_BAUD_RST 8'hff
`define LBBG_BRK_TX_BASE 5'h0d
`define LBBG_BRK_RX_MIN 5'h0b
`define LBBG_GAP_TICKS 2'h2
`define LBBG_PRESC_MAX 4'hb
`define LBBG_LAST_BIT 4'h9
`define LBBG_STOP_IDX 4'h8

`endif

// *** lbbg_brg_cnt.v ***
// one 8-bit baud counter: pulses once per k base-clock ticks (half a bit)
`timescale 1ns/100ps
module lbbg_brg_cnt #(
	parameter W = 8
) (
	input wire clock_i, // peripheral clock
	input wire rst_i, // synchronous reset, active high
	input wire clear_i, // hold counter at zero
	input wire tick_i, // base clock tick
	input wire [W-1:0] div_i, // divisor k
	output reg match_o // k ticks elapsed
);

reg [W-1:0] count;
wire [W-1:0] count_inc = count + 1'b1;
wire hit = tick_i && (count_inc == div_i);

// match is decoded, not registered: a registered pulse would be acted on
// one clock late and stretch the first bit of every frame by a clock
always @*
begin
	match_o = hit && !rst_i && !clear_i;
end

always @(posedge clock_i)
begin
	if (rst_i || clear_i)
		count <= {W{1'b0}};
	else if (hit)
		count <= {W{1'b0}};
	else if (tick_i)
		count <= count_inc;
end

endmodule

// *** lbbg_uart.v ***
// break field control and dedicated baud generator of the async serial unit
// Functional notes
// - with power set, transmit line rests high before transmission starts.
// - break send starts only on writing trigger 1 with transmit enabled.
// - break holds transmit line low 13 to 20 bits per length field.
// - break end pulses transmit-done, self-clears trigger, normal mode returns.
// - after break transmitter idles until new byte or new trigger.
// - break receive arms only with power, receive enable and trigger write.
// - armed break receive detects start and shifts like normal reception.
// - low of 11 bits or more gives receive-done, clears flag and trigger.
// - during break receive overrun, parity, framing flags never set.
// - during break receive the receive buffer is never loaded.
// - short break gives no interrupt, flag and trigger stay, rearm.
// - separate 8-bit counters time transmission and reception.
// - base clock runs from prescaler only while power is set.
// - transmit counter held zero unless power and transmit enable.
// - transmit counter clears when first byte is written.
// - back-to-back frames clear counter, else it keeps counting.
// - receive counter held zero when disabled, starts on start bit.
// - receive counter stops after a frame until next start bit.
// - bit rate is base clock over twice k, k from 8 to 255.
// - back-to-back gap gains two base-clock periods.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "lbbg_defines.vh"
module lbbg_uart #(
	parameter DW = 8,
	parameter PW = 11
) (
	input wire clock_i, // peripheral clock, 25 MHz
	input wire rst_i, // synchronous reset, active high
	input wire [3:0] addr_i, // register address
	input wire [7:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	output reg [7:0] rdata_o, // read data, cycle after rd_i
	input wire serial_rx_line_i, // receive line
	output reg serial_tx_line_o, // transmit line
	output reg tx_complete_irq_o, // frame or break sent, pulse
	output reg rx_complete_irq_o // frame or break received, pulse
);

// ----------------------------------------------------------------
// state codes
// ----------------------------------------------------------------
localparam TXS_IDLE = 2'd0;
localparam TXS_FRAME = 2'd1;
localparam TXS_GAP = 2'd2;
localparam TXS_BRK = 2'd3;
localparam RXS_IDLE = 2'd0;
localparam RXS_START = 2'd1;
localparam RXS_BITS = 2'd2;

// ----------------------------------------------------------------
// functions
// ----------------------------------------------------------------
function [PW-1:0] presc_mask;
	input [3:0] n;
	reg [3:0] m;
	begin
		m = (n > `LBBG_PRESC_MAX) ? `LBBG_PRESC_MAX : n;
		presc_mask = ~({PW{1'b1}} << m);
	end
endfunction

function [4:0] sat_inc;
	input [4:0] v;
	begin
		sat_inc = (v == 5'h1f) ? v : v + 5'h01;
	end
endfunction

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg power_control_bit;
reg transmit_enable_bit;
reg receive_enable_bit;
reg break_rx_flag;
reg break_rx_trigger;
reg break_tx_trigger;
reg [2:0] break_length_field;
reg [3:0] prescaler_select_field;
reg [DW-1:0] baud_divisor_field;
reg overrun_error_flag;
reg parity_error_flag;
reg framing_error_flag;
reg [7:0] transmit_buffer;
reg tx_pending;
reg [7:0] receive_buffer;
reg rx_buf_full;
reg [PW-1:0] presc;

reg [1:0] tx_state;
reg [9:0] tx_shift;
reg [3:0] tx_bits;
reg tx_phase;
reg [4:0] brk_bits;
reg [1:0] gap_cnt;

reg [1:0] rx_state;
reg [7:0] receive_shift_register;
reg [3:0] rx_bits;
reg rx_phase;
reg [4:0] low_bits;
reg rx_prev;

wire wr_mode = wr_i && (addr_i == `LBBG_REG_MODE);
wire wr_ctrl = wr_i && (addr_i == `LBBG_REG_CTRL);
wire wr_txbuf = wr_i && (addr_i == `LBBG_REG_TXBUF);
wire rd_err = rd_i && (addr_i == `LBBG_REG_ERR);
wire rd_rxbuf = rd_i && (addr_i == `LBBG_REG_RXBUF);

wire tx_run = power_control_bit && transmit_enable_bit;
wire rx_run = power_control_bit && receive_enable_bit;

// ----------------------------------------------------------------
// base clock and counters
// ----------------------------------------------------------------
wire [PW-1:0] pmask = presc_mask(prescaler_select_field);
// base tick stays low without power, like a clock held low
wire base_tick = power_control_bit && ((presc & pmask) == pmask);

always @(posedge clock_i)
begin
	if (rst_i || !power_control_bit)
		presc <= {PW{1'b0}};
	else
		presc <= presc + 1'b1;
end

wire tx_half;
wire rx_half;
reg tx_restart;
wire tx_clear = !tx_run || tx_restart;

// k base ticks per half bit, so a bit lasts 2k ticks
lbbg_brg_cnt #(.W(DW)) u_tx_cnt (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.clear_i(tx_clear),
	.tick_i(base_tick),
	.div_i(baud_divisor_field),
	.match_o(tx_half)
);

lbbg_brg_cnt #(.W(DW)) u_rx_cnt (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.clear_i(!rx_run || (rx_state == RXS_IDLE)),
	.tick_i(base_tick),
	.div_i(baud_divisor_field),
	.match_o(rx_half)
);

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
wire brk_tx_go = wr_ctrl && wdata_i[`LBBG_CTRL_BTT] && tx_run &&
	!break_tx_trigger && (tx_state == TXS_IDLE);
wire brk_rx_arm = wr_ctrl && wdata_i[`LBBG_CTRL_BRT] && rx_run;
reg brk_tx_done;
reg brk_rx_done;

always @(posedge clock_i)
begin
	if (rst_i)
	begin
		power_control_bit <= 1'b0;
		transmit_enable_bit <= 1'b0;
		receive_enable_bit <= 1'b0;
		break_length_field <= 3'h0;
		prescaler_select_field <= 4'h0;
		baud_divisor_field <= `LBBG_BAUD_RST;
		break_tx_trigger <= 1'b0;
		break_rx_trigger <= 1'b0;
		break_rx_flag <= 1'b0;
	end
	else
	begin
		if (wr_mode)
		begin
			power_control_bit <= wdata_i[`LBBG_MODE_POWER];
			transmit_enable_bit <= wdata_i[`LBBG_MODE_TXE];
			receive_enable_bit <= wdata_i[`LBBG_MODE_RXE];
		end
		if (wr_ctrl)
			break_length_field <= wdata_i[`LBBG_CTRL_BLEN_HI:`LBBG_CTRL_BLEN_LO];
		if (wr_i && (addr_i == `LBBG_REG_CKSEL))
			prescaler_select_field <= wdata_i[3:0];
		if (wr_i && (addr_i == `LBBG_REG_BAUD))
			baud_divisor_field <= wdata_i[DW-1:0];
		if (brk_tx_go)
			break_tx_trigger <= 1'b1;
		else if (brk_tx_done || !tx_run)
			break_tx_trigger <= 1'b0;
		// a new arming write wins over the hardware clear
		if (brk_rx_arm)
		begin
			break_rx_trigger <= 1'b1;
			break_rx_flag <= 1'b1;
		end
		else if (brk_rx_done || !rx_run)
		begin
			break_rx_trigger <= 1'b0;
			break_rx_flag <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
wire tx_bit_end = tx_half && tx_phase;
wire [4:0] brk_len = `LBBG_BRK_TX_BASE + {2'b00, break_length_field};

always @*
begin
	tx_restart = 1'b0;
	if (tx_run)
	begin
		if (tx_state == TXS_IDLE)
			tx_restart = brk_tx_go || wr_txbuf || tx_pending;
		else if (tx_state == TXS_GAP)
			tx_restart = base_tick && (gap_cnt == `LBBG_GAP_TICKS - 2'h1);
	end
end

always @(posedge clock_i)
begin
	if (rst_i || !tx_run)
	begin
		tx_state <= TXS_IDLE;
		tx_shift <= 10'h3ff;
		tx_bits <= 4'h0;
		tx_phase <= 1'b0;
		brk_bits <= 5'h0;
		gap_cnt <= 2'h0;
		tx_pending <= 1'b0;
		transmit_buffer <= 8'h00;
		serial_tx_line_o <= 1'b1;
		tx_complete_irq_o <= 1'b0;
		brk_tx_done <= 1'b0;
	end
	else
	begin
		tx_complete_irq_o <= 1'b0;
		brk_tx_done <= 1'b0;
		if (tx_half)
			tx_phase <= ~tx_phase;
		if (wr_txbuf && (tx_state != TXS_IDLE))
		begin
			transmit_buffer <= wdata_i;
			tx_pending <= 1'b1;
		end
		case (tx_state)
		TXS_IDLE:
		begin
			serial_tx_line_o <= 1'b1;
			if (brk_tx_go)
			begin
				tx_state <= TXS_BRK;
				tx_phase <= 1'b0;
				brk_bits <= 5'h0;
				serial_tx_line_o <= 1'b0;
			end
			else if (wr_txbuf || tx_pending)
			begin
				tx_shift <= {1'b1, (tx_pending ? transmit_buffer : wdata_i), 1'b0};
				tx_pending <= 1'b0;
				tx_bits <= 4'h0;
				tx_phase <= 1'b0;
				tx_state <= TXS_FRAME;
				serial_tx_line_o <= 1'b0;
			end
		end
		TXS_FRAME:
		begin
			if (tx_bit_end)
			begin
				if (tx_bits == `LBBG_LAST_BIT)
				begin
					tx_complete_irq_o <= 1'b1;
					gap_cnt <= 2'h0;
					// without a pending byte the counter keeps running
					tx_state <= tx_pending ? TXS_GAP : TXS_IDLE;
				end
				else
				begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					serial_tx_line_o <= tx_shift[1];
					tx_bits <= tx_bits + 4'h1;
				end
			end
		end
		TXS_GAP:
		begin
			if (base_tick)
				gap_cnt <= gap_cnt + 2'h1;
			if (tx_restart)
			begin
				tx_shift <= {1'b1, transmit_buffer, 1'b0};
				// a byte written at this very edge stays pending
				tx_pending <= wr_txbuf;
				tx_bits <= 4'h0;
				tx_phase <= 1'b0;
				tx_state <= TXS_FRAME;
				serial_tx_line_o <= 1'b0;
			end
		end
		TXS_BRK:
		begin
			if (tx_bit_end)
			begin
				brk_bits <= brk_bits + 5'h01;
				if (brk_bits + 5'h01 == brk_len)
				begin
					serial_tx_line_o <= 1'b1;
					tx_complete_irq_o <= 1'b1;
					brk_tx_done <= 1'b1;
					tx_state <= TXS_IDLE;
				end
			end
		end
		default:
			tx_state <= TXS_IDLE;
		endcase
	end
end

// ----------------------------------------------------------------
// receiver
// ----------------------------------------------------------------
wire rx_sample = rx_half && rx_phase;
wire rx_err_clr = rd_err;

always @(posedge clock_i)
begin
	if (rst_i)
	begin
		rx_state <= RXS_IDLE;
		rx_bits <= 4'h0;
		rx_phase <= 1'b0;
		low_bits <= 5'h0;
		rx_prev <= 1'b1;
		receive_shift_register <= 8'h00;
		receive_buffer <= `LBBG_RXBUF_RST;
		rx_buf_full <= 1'b0;
		overrun_error_flag <= 1'b0;
		parity_error_flag <= 1'b0;
		framing_error_flag <= 1'b0;
		rx_complete_irq_o <= 1'b0;
		brk_rx_done <= 1'b0;
	end
	else
	begin
		rx_prev <= serial_rx_line_i;
		rx_complete_irq_o <= 1'b0;
		brk_rx_done <= 1'b0;
		if (rd_rxbuf)
			rx_buf_full <= 1'b0;
		// reading the status clears it; a new error in the same cycle wins
		if (rx_err_clr)
		begin
			overrun_error_flag <= 1'b0;
			parity_error_flag <= 1'b0;
			framing_error_flag <= 1'b0;
		end
		if (!rx_run)
			rx_state <= RXS_IDLE;
		else
		begin
			case (rx_state)
			RXS_IDLE:
			begin
				if (rx_prev && !serial_rx_line_i)
				begin
					rx_state <= RXS_START;
					rx_phase <= 1'b0;
				end
			end
			RXS_START:
			begin
				// half a bit later the line must still be low
				if (rx_half)
				begin
					if (!serial_rx_line_i)
					begin
						rx_state <= RXS_BITS;
						rx_bits <= 4'h0;
						low_bits <= 5'h01;
						rx_phase <= 1'b0;
					end
					else
						rx_state <= RXS_IDLE;
				end
			end
			RXS_BITS:
			begin
				if (rx_half)
					rx_phase <= ~rx_phase;
				if (rx_sample)
				begin
					rx_bits <= rx_bits + 4'h1;
					if (rx_bits < `LBBG_STOP_IDX)
						receive_shift_register <= {serial_rx_line_i,
							receive_shift_register[7:1]};
					if (break_rx_trigger)
					begin
						if (!serial_rx_line_i)
							low_bits <= sat_inc(low_bits);
						else
						begin
							rx_state <= RXS_IDLE;
							if (low_bits >= `LBBG_BRK_RX_MIN)
							begin
								rx_complete_irq_o <= 1'b1;
								brk_rx_done <= 1'b1;
							end
						end
					end
					else if (rx_bits == `LBBG_STOP_IDX)
					begin
						rx_state <= RXS_IDLE;
						rx_complete_irq_o <= 1'b1;
						if (!serial_rx_line_i)
							framing_error_flag <= 1'b1;
						if (rx_buf_full && !rd_rxbuf)
							overrun_error_flag <= 1'b1;
						else
						begin
							receive_buffer <= receive_shift_register;
							rx_buf_full <= 1'b1;
						end
					end
				end
			end
			default:
				rx_state <= RXS_IDLE;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// read port
// ----------------------------------------------------------------
always @(posedge clock_i)
begin
	if (rst_i || !rd_i)
		rdata_o <= 8'h00;
	else
	begin
		case (addr_i)
		`LBBG_REG_MODE:
			rdata_o <= {power_control_bit, transmit_enable_bit,
				receive_enable_bit, 5'h00};
		`LBBG_REG_CTRL:
			rdata_o <= {break_rx_flag, break_rx_trigger, break_tx_trigger,
				break_length_field, 2'b00};
		`LBBG_REG_ERR:
			rdata_o <= {5'h00, parity_error_flag, framing_error_flag,
				overrun_error_flag};
		`LBBG_REG_TXBUF:
			rdata_o <= transmit_buffer;
		`LBBG_REG_RXBUF:
			rdata_o <= receive_buffer;
		`LBBG_REG_CKSEL:
			rdata_o <= {4'h0, prescaler_select_field};
		`LBBG_REG_BAUD:
			rdata_o <= baud_divisor_field;
		`LBBG_REG_TXSTAT:
			rdata_o <= {6'h00, tx_pending, (tx_state != TXS_IDLE)};
		default:
			rdata_o <= 8'h00;
		endcase
	end
end

endmodule

// *** lbbg_checker.sv ***
// assertion checker for the break and baud block
`timescale 1ns/100ps
module lbbg_checker #(
	parameter DW = 8,
	parameter PW = 11
) (
	input wire clock_i, // peripheral clock
	input wire rst_i, // synchronous reset
	input wire [3:0] addr_i, // register address
	input wire [7:0] wdata_i, // write data
	input wire wr_i, // write strobe
	input wire rd_i, // read strobe
	input wire [7:0] rdata_o, // read data
	input wire serial_rx_line_i, // receive line
	input wire serial_tx_line_o, // transmit line
	input wire tx_complete_irq_o, // transmit done pulse
	input wire rx_complete_irq_o // receive done pulse
);
	// ------------------------------------------------
	// shadow of power, transmit and receive enable
	// ------------------------------------------------
	reg [2:0] mode;
	always @(posedge clock_i)
		if (rst_i)
			mode <= 3'h0;
		else if (wr_i && addr_i == 4'h0)
			mode <= wdata_i[7:5];
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read cycle");
	a_unmapped_read: assert property (rd_i && addr_i[3] |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_tx_done_pulse: assert property (tx_complete_irq_o |=> !tx_complete_irq_o)
		else $error("tx done longer than a cycle");
	a_rx_done_pulse: assert property (rx_complete_irq_o |=> !rx_complete_irq_o)
		else $error("rx done longer than a cycle");
	a_tx_done_high: assert property (tx_complete_irq_o |-> serial_tx_line_o ##1 serial_tx_line_o)
		else $error("line low at tx done");
	a_power_off_idle: assert property (!mode[2] [*2] |-> serial_tx_line_o)
		else $error("line low with power off");
	a_tx_off_quiet: assert property (!(mode[2] && mode[1]) [*2] |-> serial_tx_line_o && !tx_complete_irq_o)
		else $error("transmit active while disabled");
	a_rx_off_quiet: assert property (!(mode[2] && mode[0]) [*2] |-> !rx_complete_irq_o)
		else $error("receive done while disabled");
	c_tx_done: cover property (tx_complete_irq_o);
	c_rx_done: cover property (rx_complete_irq_o);
	c_rx_fall: cover property ($fell(serial_rx_line_i));
endmodule
bind lbbg_uart lbbg_checker #(.DW(DW), .PW(PW)) lbbg_checker_i (
	.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.serial_rx_line_i(serial_rx_line_i), .serial_tx_line_o(serial_tx_line_o),
	.tx_complete_irq_o(tx_complete_irq_o),
	.rx_complete_irq_o(rx_complete_irq_o));

// *** lbbg_node.sv ***
// far bus node: sends a bit pattern lsb first on the receive line
`timescale 1ns/100ps
module lbbg_node (
	input wire clock_i, // bench clock
	input wire go_i, // start a pattern
	input wire [15:0] pat_i, // bits, lsb first
	input wire [4:0] nbits_i, // bits to send
	input wire [15:0] bper_i, // clocks per bit
	output reg line_o, // bus level, pulled high when idle
	output wire busy_o // pattern in flight
);
	reg [15:0] sh = 16'h0000;
	reg [4:0] left = 5'h00;
	reg [15:0] cnt = 16'h0000;
	initial line_o = 1'b1;
	assign busy_o = left != 5'h00;
	always @(posedge clock_i)
		if (go_i && !busy_o)
		begin
			sh <= pat_i;
			left <= nbits_i;
			cnt <= bper_i;
			line_o <= pat_i[0];
		end
		else if (busy_o && cnt == 16'h0001)
		begin
			// bit time matches the unit's own rate
			cnt <= bper_i;
			left <= left - 5'h01;
			sh <= sh >> 1;
			line_o <= (left == 5'h01) ? 1'b1 : sh[1];
		end
		else if (busy_o)
			cnt <= cnt - 16'h0001;
endmodule

// *** tb_top.sv ***
// self-checking bench for the break and baud block
`timescale 1ns/100ps
module tb_top;
	reg clock_i = 1'b0;
	reg rst_i = 1'b1;
	reg [3:0] addr_i = 4'h0;
	reg [7:0] wdata_i = 8'h00;
	reg wr_i = 1'b0;
	reg rd_i = 1'b0;
	reg go = 1'b0;
	reg [15:0] pat = 16'h0000;
	reg [4:0] nb = 5'h00;
	wire [7:0] rdata_o;
	wire rxl, txl, txirq, rxirq, busy;
	integer num_errors = 0;
	integer n_checks = 0;
	integer rxc = 0;
	integer t_fall = 0;
	integer bit_t = 16;
	integer tick, k, n, i, t0, t1;
	reg [7:0] v, d;
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i)
		if (rxirq === 1'b1)
			rxc = rxc + 1;
	always @(negedge txl)
		t_fall = $time / 40;
	lbbg_uart lbbg_uart_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.serial_rx_line_i(rxl), .serial_tx_line_o(txl),
		.tx_complete_irq_o(txirq), .rx_complete_irq_o(rxirq));
	lbbg_node lbbg_node_i (.clock_i(clock_i), .go_i(go), .pat_i(pat),
		.nbits_i(nb), .bper_i(bit_t[15:0]), .line_o(rxl), .busy_o(busy));
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks = n_checks + 1;
		if (s !== e)
		begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task timeout;
		num_errors = num_errors + 1;
		finish_test;
	endtask
	task wr(input [3:0] a, input [7:0] dd);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= dd;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [3:0] a, output [7:0] q);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 q = rdata_o;
	endtask
	task wait_line(input logic lv, output integer t);
		integer c;
		// let the line settle after the edge that may have launched it
		#1;
		for (c = 0; c < 40000 && txl !== lv; c = c + 1)
			@(posedge clock_i) #1;
		if (c >= 40000)
			timeout;
		t = $time / 40;
	endtask
	task wait_at(input integer t);
		integer c;
		for (c = 0; c < 40000 && $time / 40 < t; c = c + 1)
			@(posedge clock_i) #1;
		if (c >= 40000)
			timeout;
	endtask
	task get_frame(input [7:0] e, input integer t);
		reg [9:0] fr;
		integer j;
		fr = {1'b1, e, 1'b0};
		for (j = 0; j < 10; j = j + 1)
		begin
			wait_at(t + bit_t / 2 + j * bit_t);
			chk(txl, fr[j]);
		end
	endtask
	task send(input [15:0] p, input [4:0] nbits);
		integer c;
		@(posedge clock_i);
		pat <= p;
		nb <= nbits;
		go <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		#1;
		for (c = 0; c < 40000 && busy !== 1'b0; c = c + 1)
			@(posedge clock_i) #1;
		if (c >= 40000)
			timeout;
		repeat (2 * bit_t) @(posedge clock_i);
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial
	begin
		i = $urandom(7);
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		for (i = 0; i < 10; i = i + 1)
		begin
			rd(i[3:0], v);
			chk(v, (i == 4 || i == 6) ? 8'hff : 8'h00);
		end
		n = $urandom % 2;
		k = 8 + $urandom % 8;
		tick = 1 << n;
		bit_t = 2 * k * tick;
		wr(4'h5, n[7:0]);
		wr(4'h6, k[7:0]);
		wr(4'h0, 8'h80);
		#1 chk(txl, 1);
		wr(4'h1, 8'h20);
		repeat (4) @(posedge clock_i);
		rd(4'h1, v);
		chk({v[5], txl}, 2'h1);
		wr(4'h0, 8'he0);
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(4'h1, {3'h1, i[2:0], 2'h0});
			wait_line(1'b0, t0);
			wait_line(1'b1, t1);
			// counted in base ticks: the prescaler phase shifts the start
			chk((t1 - t0 + tick - 1) / tick, (13 + i) * 2 * k);
			chk(txirq, 1);
			rd(4'h1, v);
			chk(v[5], 0);
		end
		repeat (3 * bit_t) @(posedge clock_i);
		#1 chk(txl, 1);
		d = $urandom;
		v = $urandom;
		wr(4'h3, d);
		wr(4'h3, v);
		t0 = t_fall;
		t1 = t0 + 10 * bit_t + 2 * tick;
		get_frame(d, t0);
		wait_at(t1 - tick);
		chk(txl, 1);
		get_frame(v, t1);
		wr(4'h1, 8'h40);
		rd(4'h1, v);
		chk(v[7:6], 2'h3);
		send(16'h0000, 5'd10);
		chk(rxc, 0);
		rd(4'h1, v);
		chk(v[7:6], 2'h3);
		send(16'h0000, 5'd12);
		chk(rxc, 1);
		rd(4'h1, v);
		chk(v[7:6], 2'h0);
		rd(4'h4, v);
		chk(v, 8'hff);
		rd(4'h2, v);
		chk(v[2:0], 3'h0);
		send({6'h3f, 1'b1, d, 1'b0}, 5'd10);
		chk(rxc, 2);
		rd(4'h4, v);
		chk(v, d);
		finish_test;
	end
endmodule
